// >>> verilog/lsft_pkg.sv
package lsft_pkg;
    // ------------------------------------------------------------
    // clock and widths
    // ------------------------------------------------------------
    localparam int MCLK_HZ     = 20000000;
    localparam int NUM_CH      = 6;
    localparam int CMD_BITS    = 8;
    localparam int CNT_W       = 20;

    // ------------------------------------------------------------
    // times in their own units
    // ------------------------------------------------------------
    localparam int RETRY_WINDOW_US   = 50;   // inside 25..100 us
    localparam int REFRESH_WAIT_US   = 4500; // nominal 4.5 ms
    localparam int OFF_SENSE_US      = 60;   // typical, inside 25..100 us
    localparam int ON_SENSE_US       = 6000; // inside 3.0..12 ms
    localparam int APPLY_DELAY_NS    = 2000; // inside 1.0..10 us
    localparam int HOST_OFF_WAIT_US  = 100;
    localparam int HOST_ON_WAIT_US   = 12000;
    localparam int HOST_GAP_NS       = 1000;
    localparam int HOST_HALF_NS      = 400;  // divided serial clock half period

    // ------------------------------------------------------------
    // derived cycle counts
    // ------------------------------------------------------------
    localparam int RETRY_WINDOW_CYC  = RETRY_WINDOW_US * (MCLK_HZ / 1000000);
    localparam int REFRESH_WAIT_CYC  = REFRESH_WAIT_US * (MCLK_HZ / 1000000);
    localparam int OFF_SENSE_CYC     = OFF_SENSE_US * (MCLK_HZ / 1000000);
    localparam int ON_SENSE_CYC      = ON_SENSE_US * (MCLK_HZ / 1000000);
    localparam int APPLY_DELAY_CYC   = (APPLY_DELAY_NS * (MCLK_HZ / 1000000) + 999) / 1000;
    localparam int HOST_OFF_WAIT_CYC = HOST_OFF_WAIT_US * (MCLK_HZ / 1000000);
    localparam int HOST_ON_WAIT_CYC  = HOST_ON_WAIT_US * (MCLK_HZ / 1000000);
    localparam int HOST_GAP_CYC      = (HOST_GAP_NS * (MCLK_HZ / 1000000) + 999) / 1000;
    localparam int HOST_HALF_CYC     = (HOST_HALF_NS * (MCLK_HZ / 1000000) + 999) / 1000;

    // ------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------
    localparam int CHANNEL_CMD_BIT_LOW  = 0;
    localparam int CHANNEL_CMD_BIT_HIGH = 5;
    localparam int ON_DETECT_BIT_LO     = 6;
    localparam int ON_DETECT_BIT_HI     = 7;
    localparam logic [7:0] FAULT_RESET  = 8'h00;
endpackage

// >>> verilog/lsft_link_if.sv
`timescale 1ns/1ps
interface lsft_link_if;
    logic csN;
    logic sclk;
    logic sdi;
    logic sdoOut;
    logic sdoOeN;

    // ------------------------------------------------------------
    // ends
    // ------------------------------------------------------------
    modport device (input csN, input sclk, input sdi, output sdoOut, output sdoOeN);
    modport host   (output csN, output sclk, output sdi, input sdoOut, input sdoOeN);
endinterface

// >>> verilog/lsft_device.sv
`timescale 1ns/1ps
module lsft_device
    import lsft_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    lsft_link_if.device            link,
    input  wire logic [NUM_CH-1:0] shortDet,
    input  wire logic [NUM_CH-1:0] openDet,
    output logic      [NUM_CH-1:0] gateOn_ff,
    output logic      [NUM_CH-1:0] currentLimit_ff,
    output logic      [NUM_CH-1:0] faultReady_ff
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] csSync_ff;
    logic [2:0] clkSync_ff;
    logic [1:0] sdiSync_ff;
    logic       csFall;
    logic       csRise;
    logic       clkRise;
    logic       clkFall;
    logic       selected;

    // two stages then one history stage for edges
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            csSync_ff  <= 3'h7;
            clkSync_ff <= 3'h0;
            sdiSync_ff <= 2'h0;
        end else begin
            csSync_ff  <= {csSync_ff[1:0], link.csN};
            clkSync_ff <= {clkSync_ff[1:0], link.sclk};
            sdiSync_ff <= {sdiSync_ff[0], link.sdi};
        end
    end

    assign selected = !csSync_ff[1];
    assign csFall   = csSync_ff[2] && !csSync_ff[1];
    assign csRise   = !csSync_ff[2] && csSync_ff[1];
    assign clkRise  = selected && !clkSync_ff[2] && clkSync_ff[1];
    assign clkFall  = selected && clkSync_ff[2] && !clkSync_ff[1];

    // ------------------------------------------------------------
    // serial shift path
    // ------------------------------------------------------------
    logic [CMD_BITS-1:0] rxShift_ff;
    logic [CMD_BITS-1:0] txShift_ff;
    logic [CMD_BITS-1:0] faultReg;
    logic                bitSeen_ff;

    assign faultReg = {2'h0, faultReady_ff};

    // receive on rising clock edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rxShift_ff <= 8'h00;
        end else if (clkRise) begin
            rxShift_ff <= {rxShift_ff[CMD_BITS-2:0], sdiSync_ff[1]};
        end
    end

    // load faults at select, shift on clock fall after first rise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            txShift_ff <= FAULT_RESET;
            bitSeen_ff <= 1'b0;
        end else if (csFall) begin
            txShift_ff <= faultReg;
            bitSeen_ff <= 1'b0;
        end else begin
            if (clkRise) begin
                bitSeen_ff <= 1'b1;
            end
            if (clkFall && bitSeen_ff) begin
                txShift_ff <= {txShift_ff[CMD_BITS-2:0], 1'b0};
            end
        end
    end

    // data out and its enable
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            link.sdoOut <= 1'b0;
            link.sdoOeN <= 1'b1;
        end else begin
            link.sdoOeN <= !selected;
            link.sdoOut <= csFall ? faultReg[CMD_BITS-1] : txShift_ff[CMD_BITS-1];
        end
    end

    // ------------------------------------------------------------
    // command apply after chip select rises
    // ------------------------------------------------------------
    logic [CMD_BITS-1:0] pendCmd_ff;
    logic [CMD_BITS-1:0] activeCmd_ff;
    logic [7:0]          applyCnt_ff;
    logic                applyPend_ff;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pendCmd_ff   <= 8'h00;
            activeCmd_ff <= 8'h00;
            applyCnt_ff  <= 8'h00;
            applyPend_ff <= 1'b0;
        end else if (csRise) begin
            pendCmd_ff   <= rxShift_ff;
            applyCnt_ff  <= 8'(APPLY_DELAY_CYC);
            applyPend_ff <= 1'b1;
        end else if (applyPend_ff) begin
            if (applyCnt_ff == 8'h01) begin
                activeCmd_ff <= pendCmd_ff;
                applyPend_ff <= 1'b0;
            end
            applyCnt_ff <= applyCnt_ff - 8'h01;
        end
    end

    logic onDetectEn;
    assign onDetectEn = |activeCmd_ff[ON_DETECT_BIT_HI:ON_DETECT_BIT_LO];

    // ------------------------------------------------------------
    // per channel supervision
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CH_RUN, CH_RETRY, CH_REFRESH} lsft_ch_e;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : gCh
        lsft_ch_e         state_ff;
        logic [CNT_W-1:0] shortCnt_ff;
        logic [CNT_W-1:0] senseCnt_ff;
        logic             cmdOn;
        logic             prevOn_ff;
        logic             shortFault_ff;
        logic             openFault_ff;
        logic             senseDone;
        logic             senseLimit;

        assign cmdOn = activeCmd_ff[CHANNEL_CMD_BIT_LOW + ch];

        // short retry and refresh sequencing
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                state_ff      <= CH_RUN;
                shortCnt_ff   <= '0;
                shortFault_ff <= 1'b0;
            end else begin
                case (state_ff)
                    CH_RUN: begin
                        shortFault_ff <= 1'b0;
                        if (cmdOn && shortDet[ch]) begin
                            state_ff    <= CH_RETRY;
                            shortCnt_ff <= CNT_W'(RETRY_WINDOW_CYC - 1);
                        end
                    end
                    CH_RETRY: begin
                        if (!cmdOn) begin
                            state_ff <= CH_RUN;
                        end else if (shortCnt_ff == '0) begin
                            if (shortDet[ch]) begin
                                shortFault_ff <= 1'b1;
                                state_ff      <= CH_REFRESH;
                                shortCnt_ff   <= CNT_W'(REFRESH_WAIT_CYC - 1);
                            end else begin
                                state_ff <= CH_RUN;
                            end
                        end else begin
                            shortCnt_ff <= shortCnt_ff - CNT_W'(1);
                        end
                    end
                    CH_REFRESH: begin
                        if (!cmdOn) begin
                            state_ff <= CH_RUN;
                        end else if (shortCnt_ff == '0) begin
                            state_ff    <= CH_RETRY;
                            shortCnt_ff <= CNT_W'(RETRY_WINDOW_CYC - 1);
                        end else begin
                            shortCnt_ff <= shortCnt_ff - CNT_W'(1);
                        end
                    end
                    default: state_ff <= CH_RUN;
                endcase
            end
        end

        // open load sense timer restarts at each switch
        assign senseLimit = cmdOn ? (senseCnt_ff >= CNT_W'(ON_SENSE_CYC))
                                  : (senseCnt_ff >= CNT_W'(OFF_SENSE_CYC));
        assign senseDone  = senseLimit && (cmdOn ? onDetectEn : 1'b1);

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                prevOn_ff    <= 1'b0;
                senseCnt_ff  <= '0;
                openFault_ff <= 1'b0;
            end else begin
                prevOn_ff <= cmdOn;
                if (cmdOn != prevOn_ff) begin
                    senseCnt_ff  <= '0;
                    openFault_ff <= 1'b0;
                end else begin
                    if (!senseLimit) begin
                        senseCnt_ff <= senseCnt_ff + CNT_W'(1);
                    end
                    if (senseDone) begin
                        openFault_ff <= openDet[ch];
                    end
                end
            end
        end

        // gate drive, limit flag and fault bit ready for capture
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                gateOn_ff[ch]       <= 1'b0;
                currentLimit_ff[ch] <= 1'b0;
                faultReady_ff[ch]   <= 1'b0;
            end else begin
                gateOn_ff[ch]       <= cmdOn && (state_ff != CH_REFRESH);
                currentLimit_ff[ch] <= (state_ff == CH_RETRY);
                faultReady_ff[ch]   <= shortFault_ff || openFault_ff;
            end
        end
    end
endmodule

// >>> verilog/lsft_host.sv
`timescale 1ns/1ps
module lsft_host
    import lsft_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                arst_n,
    lsft_link_if.host                link,
    input  wire logic                xferReq,
    input  wire logic [CMD_BITS-1:0] xferCmd,
    output logic                     xferBusy_ff,
    output logic                     xferDone_ff,
    output logic      [CMD_BITS-1:0] xferStatus_ff
);
    // ------------------------------------------------------------
    // data in synchroniser
    // ------------------------------------------------------------
    logic [1:0] sdoSync_ff;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sdoSync_ff <= 2'h0;
        end else begin
            sdoSync_ff <= {sdoSync_ff[0], link.sdoOut};
        end
    end

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_LAG, H_GAP} lsft_host_e;

    lsft_host_e          state_ff;
    logic [7:0]          cnt_ff;
    logic [3:0]          bitCnt_ff;
    logic [CMD_BITS-1:0] txSh_ff;
    logic [CMD_BITS-1:0] rxSh_ff;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff      <= H_IDLE;
            cnt_ff        <= 8'h00;
            bitCnt_ff     <= 4'h0;
            txSh_ff       <= 8'h00;
            rxSh_ff       <= 8'h00;
            link.csN      <= 1'b1;
            link.sclk     <= 1'b0;
            link.sdi      <= 1'b0;
            xferBusy_ff   <= 1'b0;
            xferDone_ff   <= 1'b0;
            xferStatus_ff <= 8'h00;
        end else begin
            xferDone_ff <= 1'b0;
            case (state_ff)
                H_IDLE: begin
                    if (xferReq) begin
                        link.sclk   <= 1'b0;
                        link.csN    <= 1'b0;
                        link.sdi    <= xferCmd[CMD_BITS-1];
                        txSh_ff     <= {xferCmd[CMD_BITS-2:0], 1'b0};
                        bitCnt_ff   <= 4'(CMD_BITS);
                        cnt_ff      <= 8'(HOST_HALF_CYC - 1);
                        xferBusy_ff <= 1'b1;
                        state_ff    <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (cnt_ff == 8'h00) begin
                        link.sclk <= 1'b1;
                        cnt_ff    <= 8'(HOST_HALF_CYC - 1);
                        state_ff  <= H_HIGH;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                H_HIGH: begin
                    if (cnt_ff == 8'h00) begin
                        rxSh_ff   <= {rxSh_ff[CMD_BITS-2:0], sdoSync_ff[1]};
                        link.sclk <= 1'b0;
                        bitCnt_ff <= bitCnt_ff - 4'h1;
                        cnt_ff    <= 8'(HOST_HALF_CYC - 1);
                        if (bitCnt_ff == 4'h1) begin
                            state_ff <= H_LAG;
                        end else begin
                            link.sdi <= txSh_ff[CMD_BITS-1];
                            txSh_ff  <= {txSh_ff[CMD_BITS-2:0], 1'b0};
                            state_ff <= H_LOW;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                H_LAG: begin
                    if (cnt_ff == 8'h00) begin
                        link.csN      <= 1'b1;
                        xferStatus_ff <= rxSh_ff;
                        xferDone_ff   <= 1'b1;
                        cnt_ff        <= 8'(HOST_GAP_CYC - 1);
                        state_ff      <= H_GAP;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                H_GAP: begin
                    if (cnt_ff == 8'h00) begin
                        xferBusy_ff <= 1'b0;
                        state_ff    <= H_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                default: state_ff <= H_IDLE;
            endcase
        end
    end
endmodule

// >>> bench/lsft_link_monitor.sv
`timescale 1ns/1ps
module lsft_link_monitor
    import lsft_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdoOut,
    input wire logic sdoOeN
);
    logic [7:0] gapCnt_ff;
    logic [3:0] riseCnt_ff;
    logic       sclkPrev_ff;

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    // idle cycles since the last frame, saturating
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gapCnt_ff <= 8'hFF;
        end else if (!csN) begin
            gapCnt_ff <= 8'h00;
        end else if (gapCnt_ff != 8'hFF) begin
            gapCnt_ff <= gapCnt_ff + 8'h01;
        end
    end
    // previous link clock level
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sclkPrev_ff <= 1'h0;
        end else begin
            sclkPrev_ff <= sclk;
        end
    end
    // link clock rises inside the current frame
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            riseCnt_ff <= 4'h0;
        end else if (csN) begin
            riseCnt_ff <= 4'h0;
        end else if (sclk && !sclkPrev_ff) begin
            riseCnt_ff <= riseCnt_ff + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // link checks
    // ------------------------------------------------------------
    AST_SDO_ENABLE: assert property ($fell(csN) |-> ##[1:3] !sdoOeN)
        else $error("data out not driven after select");
    AST_SDO_RELEASE: assert property ($rose(csN) |-> ##[1:3] sdoOeN)
        else $error("data out not released after deselect");
    AST_SDO_IDLE: assert property (csN [*4] |-> sdoOeN)
        else $error("data out driven while idle");
    AST_SDO_STABLE_HIGH: assert property ((!csN && sclk && sclkPrev_ff) |-> $stable(sdoOut))
        else $error("data out moved while clock high");
    AST_SDO_SETTLED: assert property (($fell(sclk) && !csN) |-> ##5 $stable(sdoOut) [*3])
        else $error("data out late after clock fall");
    AST_SDI_HELD: assert property ($rose(sclk) |-> $stable(sdi) ##1 $stable(sdi) [*3])
        else $error("data in moved around clock rise");
    AST_CLK_LOW_AT_SELECT: assert property ($fell(csN) |-> !sclk && !sclkPrev_ff)
        else $error("clock high at select");
    AST_CLK_IDLE: assert property (csN |-> !sclk)
        else $error("clock high outside frame");
    AST_FRAME_GAP: assert property ($fell(csN) |-> gapCnt_ff >= HOST_GAP_CYC)
        else $error("frames too close");
    AST_EIGHT_BITS: assert property ($rose(csN) |-> riseCnt_ff == 4'h8)
        else $error("frame not eight bits");

    COV_FRAME_END: cover property ($rose(csN));
    COV_SDO_ON: cover property ($fell(sdoOeN));
    COV_SDO_ONE: cover property ($rose(sclk) && sdoOut);
endmodule

// >>> bench/lowside_fault_timing_test.sv
`timescale 1ns/1ps
module lowside_fault_timing_test
    import lsft_pkg::*;
;
    logic              mclk;
    logic              arst_n;
    logic              xferReq;
    logic [7:0]        xferCmd;
    logic              xferBusy;
    logic              xferDone;
    logic [7:0]        xferStatus;
    logic [NUM_CH-1:0] shortDet;
    logic [NUM_CH-1:0] openDet;
    logic [NUM_CH-1:0] gateOn;
    logic [NUM_CH-1:0] currentLimit;
    logic [NUM_CH-1:0] faultReady;
    logic [NUM_CH-1:0] gateOn2;
    logic              sclkSeen;
    logic [7:0]        wireCmd;
    logic [7:0]        wireSt;
    int                bad_count;
    int                checks;

    lsft_link_if link();
    lsft_link_if link2();

    lsft_host lsft_host_i (.mclk(mclk), .arst_n(arst_n), .link(link), .xferReq(xferReq), .xferCmd(xferCmd),
        .xferBusy_ff(xferBusy), .xferDone_ff(xferDone), .xferStatus_ff(xferStatus));
    lsft_device lsft_device_i (.mclk(mclk), .arst_n(arst_n), .link(link), .shortDet(shortDet),
        .openDet(openDet), .gateOn_ff(gateOn), .currentLimit_ff(currentLimit), .faultReady_ff(faultReady));
    lsft_device lsft_device_i2 (.mclk(mclk), .arst_n(arst_n), .link(link2), .shortDet(shortDet),
        .openDet(openDet), .gateOn_ff(gateOn2), .currentLimit_ff(), .faultReady_ff());
    lsft_link_monitor lsft_link_monitor_i (.mclk(mclk), .arst_n(arst_n), .csN(link.csN), .sclk(link.sclk),
        .sdi(link.sdi), .sdoOut(link.sdoOut), .sdoOeN(link.sdoOeN));

    // ------------------------------------------------------------
    // clock, wire capture, watchdog
    // ------------------------------------------------------------
    always #25 mclk = ~mclk;
    // both data lines shifted in at each link clock rise
    always @(posedge mclk) begin
        sclkSeen <= link.sclk;
        if (link.sclk && !sclkSeen && !link.csN) begin
            wireCmd <= {wireCmd[6:0], link.sdi};
            wireSt  <= {wireSt[6:0], link.sdoOut};
        end
    end
    // cuts a hang short
    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        $display("Error at %0t ns: watchdog expired", $time);
        conclude();
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one host transfer, judged at the user side and on the wire
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] expSt);
        int n;
        @(posedge mclk);
        xferReq <= 1'h1;
        xferCmd <= cmd;
        @(posedge mclk);
        xferReq <= 1'h0;
        n = 0;
        do begin @(posedge mclk); #1; n++; end while (xferDone !== 1'h1 && n < 400);
        chk({7'h0, n < 400}, 8'h01, "transfer never done");
        chk(xferStatus, expSt, "status byte");
        chk(wireCmd, cmd, "command on wire");
        chk(wireSt, expSt, "status on wire");
        do begin @(posedge mclk); #1; n++; end while (xferBusy !== 1'h0 && n < 800);
    endtask
    task automatic waitGate(input int ch, input logic val);
        int n;
        n = 0;
        while (gateOn[ch] !== val && n < 300) begin @(posedge mclk); #1; n++; end
        chk({7'h0, gateOn[ch]}, {7'h0, val}, "gate state");
    endtask
    // bench-made link clock of 400 ns toward the second device
    task automatic bbXfer(input logic [7:0] cmd, output logic [7:0] st);
        @(posedge mclk);
        link2.csN <= 1'h0;
        link2.sdi <= cmd[7];
        repeat (4) @(posedge mclk);
        for (int i = 7; i >= 0; i--) begin
            link2.sclk <= 1'h1;
            repeat (4) @(posedge mclk);
            st[i] = link2.sdoOut;
            link2.sclk <= 1'h0;
            if (i > 0) link2.sdi <= cmd[i-1];
            repeat (4) @(posedge mclk);
        end
        link2.csN <= 1'h1;
        link2.sdi <= ~cmd[0];
        tick(30);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testApply;
        xfer(8'hEA, 8'h00);
        chk({2'h0, gateOn}, 8'h00, "gates changed too soon");
        tick(APPLY_DELAY_CYC);
        chk({2'h0, gateOn}, 8'h2A, "gates after command");
        xfer(8'h01, 8'h00);
    endtask
    task automatic testOffOpen;
        waitGate(0, 1'h1);
        @(posedge mclk);
        openDet <= 6'h01;
        xfer(8'h00, 8'h00);
        waitGate(0, 1'h0);
        tick(OFF_SENSE_CYC - 10);
        chk({2'h0, faultReady}, 8'h00, "open load ready early");
        xfer(8'h00, 8'h00);
        chk({2'h0, faultReady}, 8'h01, "open load not ready");
        tick(HOST_OFF_WAIT_CYC - OFF_SENSE_CYC);
        xfer(8'h00, 8'h01);
    endtask
    task automatic testShort;
        int n;
        @(posedge mclk);
        shortDet <= 6'h02;
        xfer(8'h02, 8'h01);
        n = 0;
        while (currentLimit[1] !== 1'h1 && n < 400) begin @(posedge mclk); #1; n++; end
        chk({7'h0, currentLimit[1]}, 8'h01, "retry not entered");
        chk({7'h0, gateOn[1]}, 8'h01, "retry gate not on");
        n = 0;
        while (currentLimit[1] === 1'h1 && n < 3000) begin @(posedge mclk); #1; n++; end
        chk({7'h0, n >= RETRY_WINDOW_CYC - 2 && n <= RETRY_WINDOW_CYC + 2}, 8'h01, "retry length");
        n = 0;
        repeat (3000) begin @(posedge mclk); #1; if (gateOn[1] !== 1'h0 || currentLimit[1] !== 1'h0) n++; end
        chk({7'h0, n == 0}, 8'h01, "shorted output not held off");
        xfer(8'h02, 8'h03);
    endtask
    // on-state open load not ready long before its sense time
    task automatic testOnOpen;
        xfer(8'hC3, 8'h03);
        tick(2000);
        chk({2'h0, faultReady}, 8'h02, "on open load ready early");
        xfer(8'hC3, 8'h02);
    endtask
    task automatic testSecondEnd;
        logic [7:0] st;
        bbXfer(8'hD5, st);
        chk(st, 8'h01, "second status");
        chk({2'h0, gateOn2}, 8'h00, "second gates too soon");
        tick(APPLY_DELAY_CYC);
        chk({2'h0, gateOn2}, 8'h15, "second gates");
    endtask
    task automatic testReset;
        @(posedge mclk);
        arst_n <= 1'h0;
        tick(2);
        chk({2'h0, gateOn | faultReady | currentLimit}, 8'h00, "outputs in reset");
        @(posedge mclk);
        arst_n <= 1'h1;
        xfer(8'h00, 8'h00);
    endtask

    initial begin
        mclk = 1'h0;
        arst_n = 1'h0;
        xferReq = 1'h0;
        xferCmd = 8'h00;
        shortDet = 6'h00;
        openDet = 6'h00;
        link2.csN = 1'h1;
        link2.sclk = 1'h0;
        link2.sdi = 1'h0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'h1;
        tick(1);
        chk({2'h0, gateOn | faultReady}, 8'h00, "outputs after reset");
        chk({7'h0, link.sdoOeN}, 8'h01, "data out released");
        testApply();
        testOffOpen();
        testShort();
        testOnOpen();
        testSecondEnd();
        testReset();
        conclude();
    end
endmodule
